// ==== frt16_ctr.sv ====
// Counter core: 16-bit free-running count with wrap and overflow pulse
`timescale 1ns/100ps
module frt16_ctr
  import frt16_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,     // Timer clock
  input  wire logic         rst,     // Async reset, active high
  input  wire logic         run,     // Free-running mode selected
  output logic [W-1:0]      cnt,     // Registered count
  output logic              wrap     // Pulse on wrap to zero
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         wrap;
  } frt16_cst_t;

  frt16_cst_t st_r;
  frt16_cst_t st_nxt;

  // Count once per clock; at all ones the next clock gives zero and a wrap
  always_comb begin
    st_nxt      = st_r;
    st_nxt.wrap = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;                            // Cleared to zero outside mode
    end else if (st_r.cnt == {W{1'b1}}) begin
      st_nxt.cnt  = '0;
      st_nxt.wrap = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt  = st_r.cnt;
  assign wrap = st_r.wrap;

  a_wrap_zero: assert property (@(posedge clk) disable iff (rst)
    wrap |-> cnt == '0)
    else $error("wrap without zero count");
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    run && $past(run) && !wrap |-> cnt == $past(cnt) + 1'b1)
    else $error("count did not step by one");
endmodule : frt16_ctr

// ==== frt16_pkg.sv ====
// Package for the free-running 16-bit timer: offsets, fields, types
package frt16_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00; // timer_mode_control
  localparam logic [7:0] OFS_COUNT  = 8'h04; // count_value (read only)
  localparam logic [7:0] OFS_CCA    = 8'h08; // capcmp_reg_a
  localparam logic [7:0] OFS_CCB    = 8'h0c; // capcmp_reg_b
  localparam logic [7:0] OFS_STAT   = 8'h10; // sticky events, read clears
  localparam logic [7:0] OFS_MASK   = 8'h14; // interrupt enables
  localparam logic [7:0] OFS_OVF    = 8'h18; // count_overflow_flag
  // Mode register fields
  localparam int         MODE_LO_POS   = 2;  // mode_select_lo
  localparam int         MODE_HI_POS   = 3;  // mode_select_hi
  localparam int         CAP_A_POS     = 4;  // 1: reg a captures
  localparam int         CAP_B_POS     = 5;  // 1: reg b captures
  localparam logic [1:0] MODE_FREE     = 2'h1;
  localparam logic [7:0] MODE_RST      = 8'h00;
  // Status and mask bit positions
  localparam int         EV_MATCH_A = 0;
  localparam int         EV_MATCH_B = 1;
  localparam int         EV_CAP_A   = 2;
  localparam int         EV_CAP_B   = 3;
  localparam int         EV_OVF     = 4;
  localparam int         EV_W       = 5;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Register bus write-side state
  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
  } frt_wr_t;

  // Register bus read-side state
  typedef struct packed {
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } frt_rd_t;
endpackage : frt16_pkg

// ==== frt16_top.sv ====
// Free-running 16-bit timer with two capture/compare registers, AXI4-Lite
`timescale 1ns/100ps
module frt16_top
  import frt16_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic        MCLK,          // 40 MHz clock
  input  wire logic        SYS_RST,       // Async reset, active high
  input  wire logic        CAPTURE_A,     // Capture strobe for reg a
  input  wire logic        CAPTURE_B,     // Capture strobe for reg b
  output logic             MATCH_IRQ_A,   // Match pulse, reg a
  output logic             MATCH_IRQ_B,   // Match pulse, reg b
  output logic             IRQ,           // Level interrupt
  input  wire logic [7:0]  AWADDR,        // Write address
  input  wire logic        AWVALID,       // Write address valid
  output logic             AWREADY,       // Write address ready
  input  wire logic [31:0] WDATA,         // Write data
  input  wire logic [3:0]  WSTRB,         // Write strobes
  input  wire logic        WVALID,        // Write data valid
  output logic             WREADY,        // Write data ready
  output logic [1:0]       BRESP,         // Write response
  output logic             BVALID,        // Write response valid
  input  wire logic        BREADY,        // Write response ready
  input  wire logic [7:0]  ARADDR,        // Read address
  input  wire logic        ARVALID,       // Read address valid
  output logic             ARREADY,       // Read address ready
  output logic [31:0]      RDATA,         // Read data
  output logic [1:0]       RRESP,         // Read response
  output logic             RVALID,        // Read valid
  input  wire logic        RREADY         // Read ready
);
  // All block state except the count and the wrap pulse, which u_ctr holds, in one struct
  typedef struct packed {
    frt_wr_t          wr;
    frt_rd_t          rd;
    logic [7:0]       mode;
    logic [CW-1:0]    cca;
    logic [CW-1:0]    ccb;
    logic [EV_W-1:0]  stat;
    logic [EV_W-1:0]  mask;
    logic             ovf;
    logic             mt_a;
    logic             mt_b;
  } frt16_st_t;

  frt16_st_t st_r;
  frt16_st_t st_nxt;

  logic [CW-1:0] cnt;
  logic          wrap;
  logic          run;
  logic          cap_a_en;
  logic          cap_b_en;
  logic          do_wr;
  logic          do_rd;
  logic [15:0]   wlo;
  logic          at_max;

  // Flag on the clock that wraps the count, not one clock after it
  assign at_max = run && cnt == CNT_MAX;

  assign run = st_r.mode[MODE_HI_POS:MODE_LO_POS] == MODE_FREE;
  assign cap_a_en = st_r.mode[CAP_A_POS];
  assign cap_b_en = st_r.mode[CAP_B_POS];

  frt16_ctr #(
    .W    (CW)
  ) u_ctr (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .run  (run),
    .cnt  (cnt),
    .wrap (wrap)
  );

  // Address and data are each held once taken; the write fires with both
  assign AWREADY = !st_r.wr.aw_full && !st_r.wr.bvalid;
  assign WREADY  = !st_r.wr.w_full && !st_r.wr.bvalid;
  assign ARREADY = !st_r.rd.rvalid;
  assign do_rd   = ARVALID && ARREADY;
  assign wlo     = {st_r.wr.w_strb[1] ? st_r.wr.w_data[15:8] : 8'h00,
                    st_r.wr.w_data[7:0]};

  always_comb begin
    logic [CW-1:0] wv_a;
    logic [CW-1:0] wv_b;
    wv_a   = '0;
    wv_b   = '0;
    st_nxt = st_r;
    do_wr  = st_r.wr.aw_full && st_r.wr.w_full;

    // Bus channel capture
    if (AWVALID && AWREADY) begin
      st_nxt.wr.aw_full = 1'b1;
      st_nxt.wr.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      st_nxt.wr.w_full = 1'b1;
      st_nxt.wr.w_data = WDATA;
      st_nxt.wr.w_strb = WSTRB;
    end
    if (st_r.wr.bvalid && BREADY) begin
      st_nxt.wr.bvalid = 1'b0;
    end
    if (st_r.rd.rvalid && RREADY) begin
      st_nxt.rd.rvalid = 1'b0;
    end

    // Compare matches only for registers set to compare
    st_nxt.mt_a = run && !cap_a_en && cnt == st_r.cca;
    st_nxt.mt_b = run && !cap_b_en && cnt == st_r.ccb;

    // Captures latch the running count
    if (run && cap_a_en && CAPTURE_A) begin
      st_nxt.cca = cnt;
    end
    if (run && cap_b_en && CAPTURE_B) begin
      st_nxt.ccb = cnt;
    end

    // Register write; strobes of the low bytes are honoured
    if (do_wr) begin
      st_nxt.wr.aw_full = 1'b0;
      st_nxt.wr.w_full  = 1'b0;
      st_nxt.wr.bvalid  = 1'b1;
      st_nxt.wr.bresp   = RESP_OKAY;
      wv_a = {wlo[15:8] | (st_r.wr.w_strb[1] ? 8'h00 : st_r.cca[15:8]),
              st_r.wr.w_strb[0] ? wlo[7:0] : st_r.cca[7:0]};
      wv_b = {wlo[15:8] | (st_r.wr.w_strb[1] ? 8'h00 : st_r.ccb[15:8]),
              st_r.wr.w_strb[0] ? wlo[7:0] : st_r.ccb[7:0]};
      if (st_r.wr.aw_addr == OFS_MODE) begin
        if (st_r.wr.w_strb[0]) begin
          st_nxt.mode = st_r.wr.w_data[7:0];
        end
      end else if (st_r.wr.aw_addr == OFS_COUNT) begin
        st_nxt.wr.bresp = RESP_OKAY;  // Count is read only; write ignored
      end else if (st_r.wr.aw_addr == OFS_CCA) begin
        st_nxt.cca = wv_a;
      end else if (st_r.wr.aw_addr == OFS_CCB) begin
        st_nxt.ccb = wv_b;
      end else if (st_r.wr.aw_addr == OFS_STAT) begin
        st_nxt.wr.bresp = RESP_OKAY;  // Cleared by reading only
      end else if (st_r.wr.aw_addr == OFS_MASK) begin
        if (st_r.wr.w_strb[0]) begin
          st_nxt.mask = st_r.wr.w_data[EV_W-1:0];
        end
      end else if (st_r.wr.aw_addr == OFS_OVF) begin
        // Writing zero to bit 0 clears the overflow flag
        if (st_r.wr.w_strb[0] && !st_r.wr.w_data[0]) begin
          st_nxt.ovf = 1'b0;
        end
      end else begin
        st_nxt.wr.bresp = RESP_SLVERR;
      end
    end

    // Register read; the status read clears its sticky bits
    if (do_rd) begin
      st_nxt.rd.rvalid = 1'b1;
      st_nxt.rd.rresp  = RESP_OKAY;
      st_nxt.rd.rdata  = '0;
      if (ARADDR == OFS_MODE) begin
        st_nxt.rd.rdata[7:0] = st_r.mode;
      end else if (ARADDR == OFS_COUNT) begin
        st_nxt.rd.rdata[CW-1:0] = cnt;
      end else if (ARADDR == OFS_CCA) begin
        st_nxt.rd.rdata[CW-1:0] = st_r.cca;
      end else if (ARADDR == OFS_CCB) begin
        st_nxt.rd.rdata[CW-1:0] = st_r.ccb;
      end else if (ARADDR == OFS_STAT) begin
        st_nxt.rd.rdata[EV_W-1:0] = st_r.stat;
        st_nxt.stat = '0;
      end else if (ARADDR == OFS_MASK) begin
        st_nxt.rd.rdata[EV_W-1:0] = st_r.mask;
      end else if (ARADDR == OFS_OVF) begin
        st_nxt.rd.rdata[0] = st_r.ovf;
      end else begin
        st_nxt.rd.rresp = RESP_SLVERR;
      end
    end

    // Events set last so that a set beats a clear in the same cycle
    if (at_max) begin
      st_nxt.ovf          = 1'b1;
      st_nxt.stat[EV_OVF] = 1'b1;
    end
    if (st_nxt.mt_a && !st_r.mt_a) begin
      st_nxt.stat[EV_MATCH_A] = 1'b1;
    end
    if (st_nxt.mt_b && !st_r.mt_b) begin
      st_nxt.stat[EV_MATCH_B] = 1'b1;
    end
    if (run && cap_a_en && CAPTURE_A) begin
      st_nxt.stat[EV_CAP_A] = 1'b1;
    end
    if (run && cap_b_en && CAPTURE_B) begin
      st_nxt.stat[EV_CAP_B] = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r      <= '0;
      st_r.mode <= MODE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign MATCH_IRQ_A = st_r.mt_a;
  assign MATCH_IRQ_B = st_r.mt_b;
  assign IRQ         = |(st_r.stat & st_r.mask);
  assign BVALID      = st_r.wr.bvalid;
  assign BRESP       = st_r.wr.bresp;
  assign RVALID      = st_r.rd.rvalid;
  assign RDATA       = st_r.rd.rdata;
  assign RRESP       = st_r.rd.rresp;

  // Checks
  a_ovf_sets: assert property (@(posedge MCLK) disable iff (SYS_RST)
    wrap |-> st_r.ovf)
    else $error("overflow flag not set after wrap");
  a_ovf_sticky: assert property (@(posedge MCLK) disable iff (SYS_RST)
    st_r.ovf && !do_wr |=> st_r.ovf)
    else $error("overflow flag dropped without a write");
  a_run_mode: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !run |-> ##1 cnt == CNT_ZERO)
    else $error("counter moved outside free-running mode");
  a_match_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    run && !cap_a_en && cnt == st_r.cca |=> MATCH_IRQ_A)
    else $error("missed match on reg a");
  a_match_b: assert property (@(posedge MCLK) disable iff (SYS_RST)
    run && !cap_b_en && cnt == st_r.ccb |=> MATCH_IRQ_B)
    else $error("missed match on reg b");
  a_cap_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    run && cap_a_en && CAPTURE_A |=> st_r.cca == $past(cnt))
    else $error("capture a did not latch count");
  a_cap_b_mix: assert property (@(posedge MCLK) disable iff (SYS_RST)
    run && !cap_a_en && cap_b_en && CAPTURE_B
      |=> st_r.ccb == $past(cnt))
    else $error("mixed capture b did not latch");
  a_no_match_cap: assert property (@(posedge MCLK) disable iff (SYS_RST)
    cap_a_en |=> !MATCH_IRQ_A)
    else $error("capture register raised a match");
  c_wrap: cover property (@(posedge MCLK) disable iff (SYS_RST) wrap);
  c_match: cover property (@(posedge MCLK) disable iff (SYS_RST)
    MATCH_IRQ_A && MATCH_IRQ_B);
  c_capture: cover property (@(posedge MCLK) disable iff (SYS_RST)
    run && cap_a_en && cap_b_en && CAPTURE_A);
  c_irq: cover property (@(posedge MCLK) disable iff (SYS_RST) IRQ);
endmodule : frt16_top

// ==== test_free_running_timer16.sv ====
// Self-checking bench for the free-running 16-bit timer
`timescale 1ns/100ps
module test_free_running_timer16;
  import frt16_pkg::*;
  logic        MCLK, SYS_RST, CAPTURE_A, CAPTURE_B, IRQ;
  logic        MATCH_IRQ_A, MATCH_IRQ_B, AWVALID, AWREADY, WVALID;
  logic        WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [34:0] exp_q[$];  // Pending reads: {skip data, resp, data}
  logic [34:0] e;
  logic [15:0] ra, rb;
  int          n_mismatch, cmp_count, seed, n_ma, n_mb, tw, t1, t2;
  int          cyc = 0;

  frt16_top frt16_top_inst (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .CAPTURE_A(CAPTURE_A),
    .CAPTURE_B(CAPTURE_B), .MATCH_IRQ_A(MATCH_IRQ_A),
    .MATCH_IRQ_B(MATCH_IRQ_B), .IRQ(IRQ), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY)
  );

  // 40 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  // Edge counter; expected count values are derived from it
  always @(posedge MCLK) cyc <= cyc + 1;

  // Match pulses are one cycle wide, so one falling edge sees each
  always @(negedge MCLK) begin
    if (MATCH_IRQ_A === 1'b1) n_ma++;
    if (MATCH_IRQ_B === 1'b1) n_mb++;
  end

  // Read monitor: oldest note against each accepted read answer
  always @(negedge MCLK) begin
    if (RVALID === 1'b1 && RREADY === 1'b1) begin
      e = exp_q.pop_front();
      chk("rresp", 32'(RRESP), 32'(e[33:32]));
      if (!e[34] && e[33:32] === RESP_OKAY) chk("rdata", RDATA, e[31:0]);
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // A wait that ran out ends the run as a failure
  task automatic tmo(bit ok);
    if (!ok) begin
      n_mismatch++;
      summarize();
    end
  endtask : tmo

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er,
                    output int tk);
    bit aw, w, ta, tb;
    int i;
    aw = 0;
    w = 0;
    @(posedge MCLK);
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= d;
    WSTRB <= 4'hf;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    // Each channel is released only at its own take edge
    for (i = 0; i < 50 && !(aw && w); i++) begin
      @(negedge MCLK);
      tk = cyc;
      ta = AWVALID && AWREADY;
      tb = WVALID && WREADY;
      @(posedge MCLK);
      if (ta) begin
        AWVALID <= 1'b0;
        aw = 1;
      end
      if (tb) begin
        WVALID <= 1'b0;
        w = 1;
      end
    end
    tmo(aw && w);
    for (i = 0; i < 50; i++) begin
      @(negedge MCLK);
      if (BVALID === 1'b1) break;
    end
    tmo(i < 50);
    chk("bresp", 32'(BRESP), 32'(er));
    @(posedge MCLK);
    BREADY <= 1'b0;
  endtask : wr

  // Base -1: fixed data; -2: data not checked; else count since base
  task automatic rd(logic [7:0] a, logic [1:0] er, logic [31:0] ed,
                    int base);
    int i;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge MCLK);
      if (ARREADY === 1'b1) break;
    end
    tmo(i < 50);
    if (base >= 0) ed = 32'(16'(cyc - base - 2));
    exp_q.push_back({base == -2, er, ed});
    @(posedge MCLK);
    ARVALID <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(negedge MCLK);
      if (RVALID === 1'b1) break;
    end
    tmo(i < 50);
    @(posedge MCLK);
    RREADY <= 1'b0;
  endtask : rd

  task automatic rst;
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    repeat (8) @(posedge MCLK);
    SYS_RST <= 1'b0;
  endtask : rst

  // Stale events of the stopped counter are read away before the start
  task automatic go(logic [31:0] m);
    rd(OFS_STAT, RESP_OKAY, 0, -2);
    n_ma = 0;
    n_mb = 0;
    wr(OFS_MODE, m, RESP_OKAY, tw);
  endtask : go

  task automatic cap(logic [1:0] s, output int tc);
    @(posedge MCLK);
    {CAPTURE_B, CAPTURE_A} <= s;
    @(negedge MCLK);
    tc = cyc;
    @(posedge MCLK);
    {CAPTURE_B, CAPTURE_A} <= 2'h0;
  endtask : cap

  initial begin
    seed = 19;
    {CAPTURE_A, CAPTURE_B, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 0;
    {AWADDR, ARADDR, WDATA, WSTRB} = 0;
    SYS_RST = 1'b1;
    rst();
    // Reset state, unmapped and read-only places
    rd(OFS_MODE, RESP_OKAY, 0, -1);
    rd(OFS_OVF, RESP_OKAY, 0, -1);
    rd(8'h1c, RESP_SLVERR, 0, -1);
    wr(8'h1c, 1, RESP_SLVERR, t1);
    wr(OFS_COUNT, 32'h1234, RESP_OKAY, t1);
    rd(OFS_COUNT, RESP_OKAY, 0, -1);
    // Both registers compare, match interrupts unmasked
    ra = 16'(20 + ($random(seed) & 15));
    rb = 16'(40 + ($random(seed) & 15));
    wr(OFS_CCA, 32'(ra), RESP_OKAY, t1);
    wr(OFS_CCB, 32'(rb), RESP_OKAY, t1);
    wr(OFS_MASK, 32'h3, RESP_OKAY, t1);
    go(32'h4);
    repeat (80) @(negedge MCLK);
    chk("match a", 32'(n_ma), 1);
    chk("match b", 32'(n_mb), 1);
    chk("irq", 32'(IRQ), 1);
    rd(OFS_STAT, RESP_OKAY, 32'h3, -1);
    rd(OFS_CCA, RESP_OKAY, 32'(ra), -1);
    rd(OFS_COUNT, RESP_OKAY, 0, tw);
    @(negedge MCLK);
    chk("irq", 32'(IRQ), 0);
    // Reset in mid-run, then a captures while b compares, all masked
    rst();
    wr(OFS_CCB, 32'(rb), RESP_OKAY, t1);
    go(32'h14);
    repeat (1 + ($random(seed) & 7)) @(posedge MCLK);
    cap(2'h1, t1);
    repeat (70) @(negedge MCLK);
    chk("match a", 32'(n_ma), 0);
    chk("match b", 32'(n_mb), 1);
    chk("irq", 32'(IRQ), 0);
    rd(OFS_CCA, RESP_OKAY, 32'(16'(t1 - tw - 2)), -1);
    rd(OFS_STAT, RESP_OKAY, 32'h6, -1);
    // Both registers capture
    rst();
    go(32'h34);
    cap(2'h1, t1);
    repeat (1 + ($random(seed) & 7)) @(posedge MCLK);
    cap(2'h2, t2);
    rd(OFS_CCA, RESP_OKAY, 32'(16'(t1 - tw - 2)), -1);
    rd(OFS_CCB, RESP_OKAY, 32'(16'(t2 - tw - 2)), -1);
    rd(OFS_STAT, RESP_OKAY, 32'hc, -1);
    // Full wrap: sticky overflow, clear by software, stop by mode
    rst();
    wr(OFS_MASK, 32'h10, RESP_OKAY, t1);
    go(32'h4);
    repeat (65600) @(negedge MCLK);
    chk("irq", 32'(IRQ), 1);
    rd(OFS_OVF, RESP_OKAY, 1, -1);
    rd(OFS_COUNT, RESP_OKAY, 0, tw);
    rd(OFS_OVF, RESP_OKAY, 1, -1);
    rd(OFS_STAT, RESP_OKAY, 32'h13, -1);
    wr(OFS_OVF, 0, RESP_OKAY, t1);
    rd(OFS_OVF, RESP_OKAY, 0, -1);
    wr(OFS_MODE, 0, RESP_OKAY, t1);
    rd(OFS_COUNT, RESP_OKAY, 0, -1);
    summarize();
  end
endmodule : test_free_running_timer16
